/* inc/timer_pkg.sv */
`default_nettype none
package timer_pkg;
    localparam logic [7:0]  OFF_STATUS_CONTROL = 8'h00;
    localparam logic [7:0]  OFF_COUNTER_HIGH   = 8'h04;
    localparam logic [7:0]  OFF_COUNTER_LOW    = 8'h08;
    localparam logic [7:0]  OFF_MODULO_HIGH    = 8'h0C;
    localparam logic [7:0]  OFF_MODULO_LOW     = 8'h10;
    localparam logic [7:0]  OFF_CHANNEL_MODE   = 8'h14;
    localparam int          BIT_FLAG           = 7;
    localparam int          BIT_IRQ_ENABLE     = 6;
    localparam int          BIT_HALT           = 5;
    localparam int          BIT_COUNTER_RESET  = 4;
    localparam int          BIT_BUF_CH0        = 4;
    localparam int          BIT_BUF_CH2        = 5;
    localparam logic [7:0]  RESET_MODULO       = 8'hFF;
    localparam logic [15:0] RESET_COUNTER      = 16'h0000;
    localparam logic        RESET_HALT         = 1'b1;
    localparam logic [2:0]  RESET_PRESCALER    = 3'h0;
    localparam logic [5:0]  RESET_CHANNEL_MODE = 6'h00;
    localparam logic [5:0]  CHANNEL_MODE_MASK  = 6'h3F;
    localparam logic [2:0]  PS_EXTERNAL        = 3'h7;

    // Low prescaler bits that must all be one for a divided tick
    function automatic logic [5:0] div_mask(input logic [2:0] ps);
        div_mask = 6'((7'h01 << ps) - 7'h01);
    endfunction : div_mask
endpackage : timer_pkg
`default_nettype wire

/* core/tick_select.sv */
`default_nettype none
module tick_select (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Control
    input  wire logic [2:0] prescaler_select,
    input  wire logic       prescaler_clear,
    input  wire logic       run,
    // Pin
    input  wire logic       ext_timer_clock,
    // Counter enable
    output logic            tick
);
    logic [5:0] presc_reg;
    logic       ext_sync1_reg;
    logic       ext_sync2_reg;
    logic       ext_prev_reg;
    logic       ext_rise;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            presc_reg <= 6'h00;
        end
        else if (prescaler_clear)
        begin
            presc_reg <= 6'h00;
        end
        else if (run)
        begin
            presc_reg <= 6'(presc_reg + 6'h01);
        end
    end

    // Pin is slow next to the bus clock, so a rising edge on the synced copy is one tick
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg  <= 1'b0;
        end
        else
        begin
            ext_sync1_reg <= ext_timer_clock;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg  <= ext_sync2_reg;
        end
    end

    assign ext_rise = ext_sync2_reg && !ext_prev_reg;

    always_comb
    begin
        if (prescaler_select == timer_pkg::PS_EXTERNAL)
        begin
            tick = run && ext_rise;
        end
        else
        begin
            tick = run && ((presc_reg & timer_pkg::div_mask(prescaler_select))
                           == timer_pkg::div_mask(prescaler_select));
        end
    end
endmodule : tick_select
`default_nettype wire

/* core/timer_counter_control.sv */
`default_nettype none
module timer_counter_control (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // System state
    input  wire logic        stop_mode,
    input  wire logic        break_state,
    input  wire logic        break_clear_enable,
    // External timer clock pin
    input  wire logic        ext_timer_clock,
    // Channel pins
    input  wire logic [3:0]  channel_pins_in,
    output logic [3:0]       channel_pins_out,
    output logic [3:0]       channel_pins_oe,
    output logic [3:0]       capture_pulse,
    // Interrupt request
    output logic             overflow_irq
);
    logic [7:0]  dphase_addr_reg;
    logic        dphase_wr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] read_val;
    logic        addr_take;
    logic        rd_take;
    logic [7:0]  wbyte;
    logic        wr_tsc;
    logic        wr_modh;
    logic        wr_modl;
    logic        wr_chan;
    logic        rd_tsc;
    logic        rd_cnth;
    logic        rd_cntl;

    logic        overflow_flag_reg;
    logic        overflow_irq_enable_reg;
    logic        counter_halt_reg;
    logic [2:0]  prescaler_select_reg;
    logic        armed_reg;
    logic [15:0] counter_reg;
    logic [15:0] counter_next;
    logic [15:0] modulo;
    logic [7:0]  modulo_high_reg;
    logic [7:0]  modulo_low_reg;
    logic        mod_pending_reg;
    logic [7:0]  latched_low_reg;
    logic        latch_valid_reg;
    logic [5:0]  channel_mode_reg;
    logic [3:0]  chan_sync1_reg;
    logic [3:0]  chan_sync2_reg;
    logic [3:0]  chan_prev_reg;
    logic [3:0]  capture_pulse_reg;
    logic [3:0]  chan_out_reg;

    logic        protect;
    logic        run;
    logic        tick;
    logic        trst_write;
    logic        clr_write;
    logic        ovf_event;
    logic [3:0]  compare_mode;

    // Bus front end: zero wait states, every answer OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    assign addr_take = hsel && htrans[1] && hready;
    assign rd_take   = addr_take && !hwrite;
    assign wbyte     = hwdata[7:0];
    assign rd_tsc    = rd_take && (haddr[7:0] == timer_pkg::OFF_STATUS_CONTROL);
    assign rd_cnth   = rd_take && (haddr[7:0] == timer_pkg::OFF_COUNTER_HIGH);
    assign rd_cntl   = rd_take && (haddr[7:0] == timer_pkg::OFF_COUNTER_LOW);
    assign wr_tsc    = dphase_wr_reg && (dphase_addr_reg == timer_pkg::OFF_STATUS_CONTROL);
    assign wr_modh   = dphase_wr_reg && (dphase_addr_reg == timer_pkg::OFF_MODULO_HIGH);
    assign wr_modl   = dphase_wr_reg && (dphase_addr_reg == timer_pkg::OFF_MODULO_LOW);
    assign wr_chan   = dphase_wr_reg && (dphase_addr_reg == timer_pkg::OFF_CHANNEL_MODE);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dphase_wr_reg   <= 1'b0;
            dphase_addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            dphase_wr_reg   <= addr_take && hwrite;
            dphase_addr_reg <= haddr[7:0];
        end
    end

    // Read data is sampled at the address phase so that it pairs with the read side effects
    always_comb
    begin
        read_val = 32'h0000_0000;
        case (haddr[7:0])
            timer_pkg::OFF_STATUS_CONTROL:
                read_val[7:0] = {overflow_flag_reg, overflow_irq_enable_reg, counter_halt_reg,
                                 2'b00, prescaler_select_reg};
            timer_pkg::OFF_COUNTER_HIGH:
                read_val[7:0] = counter_reg[15:8];
            timer_pkg::OFF_COUNTER_LOW:
                read_val[7:0] = latch_valid_reg ? latched_low_reg : counter_reg[7:0];
            timer_pkg::OFF_MODULO_HIGH:
                read_val[7:0] = modulo_high_reg;
            timer_pkg::OFF_MODULO_LOW:
                read_val[7:0] = modulo_low_reg;
            timer_pkg::OFF_CHANNEL_MODE:
                read_val[7:0] = {2'b00, channel_mode_reg};
            default:
                read_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hrdata_reg <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            hrdata_reg <= read_val;
        end
    end

    // Status protection while the debugger holds the part
    assign protect    = break_state && !break_clear_enable;
    assign run        = !counter_halt_reg && !stop_mode && !break_state;
    assign trst_write = wr_tsc && wbyte[timer_pkg::BIT_COUNTER_RESET];
    assign clr_write  = wr_tsc && !wbyte[timer_pkg::BIT_FLAG] && armed_reg && !protect;
    assign modulo     = {modulo_high_reg, modulo_low_reg};

    tick_select u_tick (
        .clock            (clock),
        .rst_b            (rst_b),
        .prescaler_select (prescaler_select_reg),
        .prescaler_clear  (trst_write),
        .run              (run),
        .ext_timer_clock  (ext_timer_clock),
        .tick             (tick)
    );

    always_comb
    begin
        if (counter_reg == modulo)
        begin
            counter_next = 16'h0000;
        end
        else
        begin
            counter_next = 16'(counter_reg + 16'h0001);
        end
    end

    assign ovf_event = tick && !trst_write && (counter_next == modulo) && !mod_pending_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            counter_reg <= timer_pkg::RESET_COUNTER;
        end
        else if (trst_write)
        begin
            counter_reg <= 16'h0000;
        end
        else if (tick)
        begin
            counter_reg <= counter_next;
        end
    end

    // Control bits are never protected by break; only the flag is
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            overflow_irq_enable_reg <= 1'b0;
            counter_halt_reg        <= timer_pkg::RESET_HALT;
            prescaler_select_reg    <= timer_pkg::RESET_PRESCALER;
        end
        else if (wr_tsc)
        begin
            overflow_irq_enable_reg <= wbyte[timer_pkg::BIT_IRQ_ENABLE];
            counter_halt_reg        <= wbyte[timer_pkg::BIT_HALT];
            prescaler_select_reg    <= wbyte[2:0];
        end
    end

    // A new overflow wins over a clear in the same cycle and disarms the sequence
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            overflow_flag_reg <= 1'b0;
            armed_reg         <= 1'b0;
        end
        else
        begin
            if (ovf_event)
            begin
                overflow_flag_reg <= 1'b1;
            end
            else if (clr_write)
            begin
                overflow_flag_reg <= 1'b0;
            end
            if (ovf_event)
            begin
                armed_reg <= 1'b0;
            end
            else if (rd_tsc && overflow_flag_reg && !protect)
            begin
                armed_reg <= 1'b1;
            end
            else if (clr_write)
            begin
                armed_reg <= 1'b0;
            end
        end
    end

    // Level request; also serves as the wake source in wait mode
    assign overflow_irq = overflow_flag_reg && overflow_irq_enable_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modulo_high_reg <= timer_pkg::RESET_MODULO;
            modulo_low_reg  <= timer_pkg::RESET_MODULO;
            mod_pending_reg <= 1'b0;
        end
        else if (wr_modh)
        begin
            modulo_high_reg <= wbyte;
            mod_pending_reg <= 1'b1;
        end
        else if (wr_modl)
        begin
            modulo_low_reg  <= wbyte;
            mod_pending_reg <= 1'b0;
        end
    end

    // Latch is released only by a low read, so it outlives a break
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latched_low_reg <= 8'h00;
            latch_valid_reg <= 1'b0;
        end
        else if (rd_cnth)
        begin
            latch_valid_reg <= 1'b1;
            if (!latch_valid_reg)
            begin
                latched_low_reg <= counter_reg[7:0];
            end
        end
        else if (rd_cntl)
        begin
            latch_valid_reg <= 1'b0;
        end
    end

    // Channel mode: low nibble compare(1)/capture(0), buffered bits for channels 0 and 2 only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            channel_mode_reg <= timer_pkg::RESET_CHANNEL_MODE;
        end
        else if (wr_chan)
        begin
            channel_mode_reg <= wbyte[5:0] & timer_pkg::CHANNEL_MODE_MASK;
        end
    end

    assign compare_mode = channel_mode_reg[3:0];

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chan_sync1_reg <= 4'h0;
            chan_sync2_reg <= 4'h0;
            chan_prev_reg  <= 4'h0;
        end
        else
        begin
            chan_sync1_reg <= channel_pins_in;
            chan_sync2_reg <= chan_sync1_reg;
            chan_prev_reg  <= chan_sync2_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            capture_pulse_reg <= 4'h0;
        end
        else
        begin
            capture_pulse_reg <= (chan_sync2_reg ^ chan_prev_reg) & ~compare_mode
                                 & {4{!counter_halt_reg}};
        end
    end

    assign capture_pulse = capture_pulse_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chan_out_reg <= 4'h0;
        end
        else if (ovf_event)
        begin
            chan_out_reg <= chan_out_reg ^ compare_mode;
        end
    end

    // A buffered pair hands its odd pin back to general-purpose use
    assign channel_pins_out = chan_out_reg;
    assign channel_pins_oe  = compare_mode & ~{channel_mode_reg[timer_pkg::BIT_BUF_CH2], 1'b0,
                                               channel_mode_reg[timer_pkg::BIT_BUF_CH0], 1'b0};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence clear_req_s;
        armed_reg && clr_write && !ovf_event;
    endsequence

    sequence arm_s;
        rd_tsc && overflow_flag_reg && !protect && !ovf_event;
    endsequence

    halt_hold_a: assert property (counter_halt_reg && !trst_write |=> $stable(counter_reg))
        else $error("counter moved while halted");
    stop_hold_a: assert property (stop_mode && !trst_write |=> $stable(counter_reg))
        else $error("counter moved in stop mode");
    break_hold_a: assert property (break_state && !trst_write |=> $stable(counter_reg))
        else $error("counter moved in break");
    wrap_zero_a: assert property (tick && !trst_write && counter_reg == modulo |=> counter_reg == 16'h0000)
        else $error("counter did not wrap to zero");
    flag_set_a: assert property (ovf_event |=> overflow_flag_reg && !armed_reg)
        else $error("overflow did not set flag");
    irq_gate_a: assert property (ovf_event && overflow_irq_enable_reg && !wr_tsc |=> overflow_irq)
        else $error("enabled overflow raised no irq");
    flag_clear_a: assert property (clear_req_s |=> !overflow_flag_reg)
        else $error("armed clear failed");
    arm_then_a: assert property (arm_s |=> armed_reg)
        else $error("flag read did not arm clear");
    flag_keep_a: assert property (overflow_flag_reg && (!armed_reg || protect) |=> overflow_flag_reg)
        else $error("flag cleared without armed unprotected write");
    trst_zero_a: assert property (trst_write |=> counter_reg == 16'h0000)
        else $error("counter reset did not clear counter");
    mod_block_a: assert property (mod_pending_reg |=> !$rose(overflow_flag_reg))
        else $error("flag set while modulo half written");
    capture_inhibit_a: assert property ($past(counter_halt_reg) |-> capture_pulse == 4'h0)
        else $error("capture while halted");
    latch_hold_a: assert property (latch_valid_reg && !rd_cntl |=> $stable(latched_low_reg))
        else $error("latched low byte changed");
endmodule : timer_counter_control
`default_nettype wire

/* sim/timer_counter_control_tb.sv */
`default_nettype none
module timer_counter_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] S_A  = timer_pkg::OFF_STATUS_CONTROL;
    localparam logic [7:0] CH_A = timer_pkg::OFF_COUNTER_HIGH;
    localparam logic [7:0] CL_A = timer_pkg::OFF_COUNTER_LOW;
    localparam logic [7:0] MH_A = timer_pkg::OFF_MODULO_HIGH;
    localparam logic [7:0] ML_A = timer_pkg::OFF_MODULO_LOW;

    logic        clock;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        stop_mode;
    logic        break_state;
    logic        break_clear_enable;
    logic        ext_timer_clock;
    logic [3:0]  channel_pins_in;
    logic [3:0]  channel_pins_out;
    logic [3:0]  channel_pins_oe;
    logic [3:0]  capture_pulse;
    logic        overflow_irq;
    int          err_count;
    int          checks_done;
    logic [15:0] va;
    logic [15:0] vb;
    logic [7:0]  r;

    timer_counter_control u_dut (
        .clock              (clock),
        .rst_b              (rst_b),
        .hsel               (hsel),
        .haddr              (haddr),
        .htrans             (htrans),
        .hwrite             (hwrite),
        .hsize              (hsize),
        .hwdata             (hwdata),
        .hready             (hreadyout),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .hrdata             (hrdata),
        .stop_mode          (stop_mode),
        .break_state        (break_state),
        .break_clear_enable (break_clear_enable),
        .ext_timer_clock    (ext_timer_clock),
        .channel_pins_in    (channel_pins_in),
        .channel_pins_out   (channel_pins_out),
        .channel_pins_oe    (channel_pins_oe),
        .capture_pulse      (capture_pulse),
        .overflow_irq       (overflow_irq)
    );

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single transfer; the slave's answer is awaited, never assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata[7:0];
        check("hresp", hresp, 1'b0);
        check("hreadyout", hreadyout, 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        check(name, x, exp);
    endtask : rd_chk

    task automatic cnt(output logic [15:0] v);
        bus(1'b0, CH_A, 8'h00, v[15:8]);
        bus(1'b0, CL_A, 8'h00, v[7:0]);
    endtask : cnt

    task automatic wait_irq(input logic exp, input int lim);
        int n;
        n = 0;
        while (overflow_irq !== exp && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        check("overflow_irq", overflow_irq, exp);
    endtask : wait_irq

    task automatic wait_pulse(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge clock);
            seen = seen | capture_pulse[1];
        end
        check("capture_pulse", seen, exp);
    endtask : wait_pulse

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // A run far longer than all tests together means a hang
    initial
    begin
        repeat (60000) @(posedge clock);
        err_count++;
        final_report();
    end

    initial
    begin
        err_count = 0;
        checks_done = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        stop_mode = 1'b0;
        break_state = 1'b0;
        break_clear_enable = 1'b0;
        ext_timer_clock = 1'b0;
        channel_pins_in = 4'h0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;

        rd_chk("status", S_A, 8'h20);
        rd_chk("counter_high", CH_A, 8'h00);
        rd_chk("counter_low", CL_A, 8'h00);
        rd_chk("modulo_high", MH_A, 8'hFF);
        rd_chk("modulo_low", ML_A, 8'hFF);
        rd_chk("unmapped", 8'h3C, 8'h00);
        check("overflow_irq", overflow_irq, 1'b0);
        $display("test reset values done");

        for (int n = 0; n < 7; n++)
        begin
            wr(S_A, 8'h30 | 8'(n));
            cnt(va);
            repeat (20) @(posedge clock);
            cnt(vb);
            check("halted at zero", {va, vb}, 32'h00000000);
            rd_chk("reset bit reads 0", S_A, 8'h20 | 8'(n));
            wr(S_A, 8'(n));
            repeat (512) @(posedge clock);
            wr(S_A, 8'h20 | 8'(n));
            cnt(va);
            check("prescale", (va + 16'd3 >= (16'd515 >> n)) && (va <= (16'd515 >> n) + 16'd3), 1'b1);
        end
        wr(S_A, 8'h37);
        wr(S_A, 8'(timer_pkg::PS_EXTERNAL));
        // Pin period of fourteen bus cycles keeps under both 4 MHz and half the bus rate
        repeat (10)
        begin
            ext_timer_clock <= 1'b1;
            repeat (7) @(posedge clock);
            ext_timer_clock <= 1'b0;
            repeat (7) @(posedge clock);
        end
        repeat (8) @(posedge clock);
        cnt(va);
        check("pin ticks", va, 16'h000A);
        $display("test prescaler done");

        for (int k = 0; k < 2; k++)
        begin
            wr(S_A, 8'h00);
            stop_mode <= (k == 0);
            break_state <= (k == 1);
            repeat (3) @(posedge clock);
            cnt(va);
            repeat (30) @(posedge clock);
            cnt(vb);
            check("frozen counter", vb, va);
            stop_mode <= 1'b0;
            break_state <= 1'b0;
            repeat (10) @(posedge clock);
            cnt(vb);
            check("counting resumed", vb != va, 1'b1);
        end
        wr(S_A, 8'h20);
        cnt(va);
        break_state <= 1'b1;
        bus(1'b0, CH_A, 8'h00, r);
        break_state <= 1'b0;
        wr(S_A, 8'h00);
        repeat (50) @(posedge clock);
        wr(S_A, 8'h20);
        bus(1'b0, CH_A, 8'h00, r);
        rd_chk("latched low", CL_A, va[7:0]);
        $display("test freeze and latch done");

        wr(S_A, 8'h30);
        wr(MH_A, 8'h00);
        wr(ML_A, 8'h05);
        wr(S_A, 8'h40);
        wait_irq(1'b1, 20);
        wr(S_A, 8'h60);
        rd_chk("unarmed clear", S_A, 8'hE0);
        wr(S_A, 8'hE0);
        rd_chk("write one", S_A, 8'hE0);
        break_state <= 1'b1;
        wr(S_A, 8'h60);
        rd_chk("protected", S_A, 8'hE0);
        break_state <= 1'b0;
        wr(S_A, 8'h60);
        rd_chk("second step", S_A, 8'h60);
        check("overflow_irq", overflow_irq, 1'b0);
        wr(S_A, 8'h40);
        wait_irq(1'b1, 20);
        wr(S_A, 8'h60);
        break_state <= 1'b1;
        break_clear_enable <= 1'b1;
        rd_chk("armed in break", S_A, 8'hE0);
        wr(S_A, 8'h60);
        break_state <= 1'b0;
        break_clear_enable <= 1'b0;
        rd_chk("cleared in break", S_A, 8'h60);
        wr(S_A, 8'h00);
        repeat (20) @(posedge clock);
        check("irq disabled", overflow_irq, 1'b0);
        rd_chk("flag no irq", S_A, 8'h80);
        $display("test overflow flag done");

        // A further overflow disarms the read above, so the halting write leaves the flag set
        repeat (8) @(posedge clock);
        wr(S_A, 8'h30);
        wr(MH_A, 8'h00);
        wr(S_A, 8'h00);
        rd_chk("flag kept", S_A, 8'h80);
        wr(S_A, 8'h00);
        repeat (40) @(posedge clock);
        rd_chk("flag blocked", S_A, 8'h00);
        wr(ML_A, 8'h05);
        repeat (20) @(posedge clock);
        rd_chk("flag unblocked", S_A, 8'h80);
        channel_pins_in[1] <= 1'b1;
        wait_pulse(1'b1);
        wr(S_A, 8'h20);
        channel_pins_in[1] <= 1'b0;
        wait_pulse(1'b0);
        $display("test modulo and capture done");

        wr(timer_pkg::OFF_CHANNEL_MODE, 8'h1F);
        rd_chk("channel_mode", timer_pkg::OFF_CHANNEL_MODE, 8'h1F);
        check("channel_pins_oe", channel_pins_oe, 4'hD);
        wr(S_A, 8'h30);
        check("channel_pins_out", channel_pins_out, 4'h0);
        // Modulo 5 from zero: first overflow five ticks in, the next six later
        wr(S_A, 8'h00);
        repeat (7) @(posedge clock);
        check("channel_pins_out", channel_pins_out, 4'hF);
        $display("test channel pins done");

        stop_mode <= 1'b1;
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        stop_mode <= 1'b0;
        rd_chk("status", S_A, 8'h20);
        rd_chk("modulo_low", ML_A, 8'hFF);
        cnt(va);
        check("counter", va, 16'h0000);
        rd_chk("channel_mode", timer_pkg::OFF_CHANNEL_MODE, 8'h00);
        check("channel_pins_oe", channel_pins_oe, 4'h0);
        $display("test reset in stop done");
        final_report();
    end
endmodule : timer_counter_control_tb
`default_nettype wire
